// file: isa_cycle_params.svh
// Timing counts, offsets and reset values for the ISA bus cycle block.
// Assumes pclk at 125 MHz; all bus phases are counted in 50 ns network clocks.
`ifndef ISA_CYCLE_PARAMS_SVH
`define ISA_CYCLE_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_NS        8
`define NCLK_NS        50
`define NCLK_CYC       ((`NCLK_NS + `PCLK_NS - 1) / `PCLK_NS)
`define ACQ_NCLK       4'h3
`define SETUP_NCLK     4'h1
`define DHOLD_NCLK     4'h1
`define REC_FAST_NCLK  4'h2
`define REC_SLOW_NCLK  4'h4
`define ROMCS_NCLK     4'h3

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define WAT_RESET      4'h5
`define CFG_RESET      16'h0010
`define CFG_REC_BIT    4
`define IDX_WAT        2'h1
`define IDX_CFG        2'h2

// ----------------------------------------
// ISA I/O map (offset is SA4..SA0)
// ----------------------------------------
`define IO_BASE_HI     5'h18
`define IOFS_RDP       5'h10
`define IOFS_RAP       5'h12
`define IOFS_RST       5'h14
`define IOFS_IDP       5'h16

// ----------------------------------------
// APB map
// ----------------------------------------
`define APB_CMD        12'h000
`define APB_MW_ADDR    12'h004
`define APB_MW_DATA    12'h008
`define APB_OPTS       12'h00C
`define APB_STATUS     12'h010
`define APB_CFG        12'h014

`endif

// file: isa_cycle_pkg.sv
// Types shared by the ISA bus cycle block.
// Assumes nothing of its surroundings.
package isa_cycle_pkg;

  typedef enum logic [2:0] {
    MW_IDLE   = 3'b000,
    MW_REQ    = 3'b001,
    MW_ACQ    = 3'b010,
    MW_SETUP  = 3'b011,
    MW_ACTIVE = 3'b100,
    MW_HOLD   = 3'b101,
    MW_RECOV  = 3'b110
  } mw_state_type;

  typedef enum logic [2:0] {
    SL_IDLE      = 3'b000,
    SL_REG       = 3'b001,
    SL_PROM_WAIT = 3'b010,
    SL_PROM_DRV  = 3'b011,
    SL_ROM_LO    = 3'b100,
    SL_ROM_HI    = 3'b101,
    SL_DONE      = 3'b110
  } sl_state_type;

endpackage

// file: isa_bus_cycle.sv
// ISA bus cycle logic: master memory write and I/O register, address PROM and boot ROM slave cycles.
// Assumes ISA inputs are synchronous to pclk; open-drain pins use _oe = pull low.
//
// Our own choices: the APB register port and the register offsets.
`include "isa_cycle_params.svh"
`timescale 1ns/1ps
`default_nettype none

module isa_bus_cycle (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // ISA inputs
  input  wire logic        aen,
  input  wire logic [19:0] sa_in,
  input  wire logic        sbhe_n_in,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic        memr_n,
  input  wire logic        iochrdy_in,
  input  wire logic        dack_n,
  input  wire logic        boot_rom_match,
  input  wire logic [15:0] sd_in,
  // ISA outputs
  output logic      [19:0] sa_out,
  output logic      [6:0]  la_out,
  output logic             sbhe_n_out,
  output logic             addr_oe,
  output logic             memw_n_out,
  output logic             cmd_oe,
  output logic      [15:0] sd_out,
  output logic             sd_lo_oe,
  output logic             sd_hi_oe,
  output logic             iochrdy_oe,
  output logic             iocs16_oe,
  output logic             drq,
  output logic             master_n,
  // Private bus
  input  wire logic        private_bus_busy,
  input  wire logic [7:0]  private_data_lines,
  output logic      [15:0] private_addr,
  output logic             addr_prom_select_n,
  output logic             boot_rom_select_n,
  // Core reset request
  output logic             core_reset
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  isa_cycle_pkg::mw_state_type mw_q;
  isa_cycle_pkg::sl_state_type sl_q;
  logic [7:0]  mw_cnt_q;
  logic [7:0]  sl_cnt_q;
  logic [23:0] mw_addr_q;
  logic [15:0] mw_data_q;
  logic        mw_pend_q;
  logic [1:0]  opts_q;
  logic [3:0]  wat_q;
  logic [15:0] cfg_q;
  logic [15:0] rap_q;
  logic [15:0] csr_q [0:3];
  logic [7:0]  hold_q;
  logic        sbhe_seen_q;
  logic        srst_q;
  logic        cyc_rst_q;
  logic [15:0] sd_q;
  logic        sd_lo_q;
  logic        sd_hi_q;
  logic [15:0] rom_addr_q;
  logic [31:0] prdata_q;
  logic        eight_bit;
  logic        io_hit;
  logic [4:0]  io_ofs;
  logic        reg_ofs;
  logic [15:0] reg_rd;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        apb_wr;
  logic        apb_map;
  logic        mw_drive;
  logic [3:0]  rec_nclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // True in the last pclk of an n network clock phase
  function automatic logic phase_end(input logic [7:0] cnt, input logic [3:0] n);
    phase_end = ({1'b0, cnt} + 9'h001) >= (9'(n) * 9'(`NCLK_CYC));
  endfunction

  function automatic logic [15:0] bus_cfg_read(input logic [1:0] idx, input logic [3:0] wat,
                                                input logic [15:0] cfg);
    bus_cfg_read = 16'h0000;
    if (idx == `IDX_WAT) begin
      bus_cfg_read = {12'h000, wat};
    end else if (idx == `IDX_CFG) begin
      bus_cfg_read = cfg;
    end
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // A first 16-bit host cycle counts at once, so data width and lanes agree
  assign eight_bit = !(sbhe_seen_q || (!sbhe_n_in && master_n)) || opts_q[0];
  assign io_hit    = !aen && (sa_in[9:5] == `IO_BASE_HI);
  assign io_ofs    = sa_in[4:0];
  assign reg_ofs   = ({io_ofs[4:1], 1'b0} == `IOFS_RDP) || ({io_ofs[4:1], 1'b0} == `IOFS_RAP) ||
                     ({io_ofs[4:1], 1'b0} == `IOFS_IDP);
  assign rec_nclk  = cfg_q[`CFG_REC_BIT] ? `REC_FAST_NCLK : `REC_SLOW_NCLK;
  assign mw_drive  = (mw_q == isa_cycle_pkg::MW_SETUP) || (mw_q == isa_cycle_pkg::MW_ACTIVE) ||
                     (mw_q == isa_cycle_pkg::MW_HOLD);

  always_comb begin
    reg_rd = 16'h0000;
    unique case ({io_ofs[4:1], 1'b0})
      `IOFS_RDP: reg_rd = csr_q[rap_q[1:0]];
      `IOFS_RAP: reg_rd = rap_q;
      `IOFS_IDP: reg_rd = bus_cfg_read(rap_q[1:0], wat_q, cfg_q);
      default:   reg_rd = 16'h0000;
    endcase
  end

  // A write is committed at the first cycle of the I/O command
  always_comb begin
    reg_wr    = 1'b0;
    reg_wdata = sd_in;
    if (sl_q == isa_cycle_pkg::SL_IDLE && io_hit && !iow_n && ior_n && reg_ofs) begin
      if (!eight_bit) begin
        reg_wr = 1'b1;
      end else if (io_ofs[0]) begin
        reg_wr    = 1'b1;
        reg_wdata = {sd_in[7:0], hold_q};
      end
    end
  end

  // ----------------------------------------
  // Soft reset and bus width detect
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= (sl_q == isa_cycle_pkg::SL_IDLE) && io_hit && !ior_n && (io_ofs == `IOFS_RST);
    end
  end

  assign core_reset = srst_q;

  // Our own SBHE drive while master must not count as a 16-bit host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sbhe_seen_q <= 1'b0;
    end else if (srst_q) begin
      sbhe_seen_q <= 1'b0;
    end else if (!sbhe_n_in && (master_n)) begin
      sbhe_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registers reached from ISA
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rap_q  <= 16'h0000;
      hold_q <= 8'h00;
      wat_q  <= `WAT_RESET;
      cfg_q  <= `CFG_RESET;
      for (int i = 0; i < 4; i++) begin
        csr_q[i] <= 16'h0000;
      end
    end else if (srst_q) begin
      rap_q  <= 16'h0000;
      hold_q <= 8'h00;
      wat_q  <= `WAT_RESET;
      cfg_q  <= `CFG_RESET;
      for (int i = 0; i < 4; i++) begin
        csr_q[i] <= 16'h0000;
      end
    end else begin
      if (sl_q == isa_cycle_pkg::SL_IDLE && io_hit && !iow_n && ior_n && reg_ofs && eight_bit &&
          !io_ofs[0]) begin
        hold_q <= sd_in[7:0];
      end
      if (reg_wr) begin
        unique case ({io_ofs[4:1], 1'b0})
          `IOFS_RDP: csr_q[rap_q[1:0]] <= reg_wdata;
          `IOFS_RAP: rap_q <= reg_wdata;
          `IOFS_IDP: begin
            if (rap_q[1:0] == `IDX_WAT) begin
              wat_q <= reg_wdata[3:0];
            end else if (rap_q[1:0] == `IDX_CFG) begin
              cfg_q <= reg_wdata;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Slave cycle sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_q       <= isa_cycle_pkg::SL_IDLE;
      sl_cnt_q   <= 8'h00;
      cyc_rst_q  <= 1'b0;
      sd_q       <= 16'h0000;
      sd_lo_q    <= 1'b0;
      sd_hi_q    <= 1'b0;
      rom_addr_q <= 16'h0000;
    end else begin
      unique case (sl_q)
        isa_cycle_pkg::SL_IDLE: begin
          sl_cnt_q <= 8'h00;
          sd_lo_q  <= 1'b0;
          sd_hi_q  <= 1'b0;
          if (io_hit && !ior_n && !io_ofs[4]) begin
            sl_q <= isa_cycle_pkg::SL_PROM_WAIT;
          end else if (io_hit && (!ior_n || !iow_n) && (reg_ofs || io_ofs == `IOFS_RST)) begin
            sl_q      <= isa_cycle_pkg::SL_REG;
            cyc_rst_q <= (io_ofs == `IOFS_RST);
            if (eight_bit) begin
              sd_q <= {8'h00, io_ofs[0] ? reg_rd[15:8] : reg_rd[7:0]};
            end else begin
              sd_q <= reg_rd;
            end
          end else if (!memr_n && boot_rom_match) begin
            sl_q       <= isa_cycle_pkg::SL_ROM_LO;
            rom_addr_q <= eight_bit ? sa_in[15:0] : {sa_in[15:1], 1'b0};
          end
        end
        isa_cycle_pkg::SL_REG: begin
          // Data captured on entry is ready now; release the bus next
          sl_q     <= isa_cycle_pkg::SL_DONE;
          sd_lo_q  <= !ior_n && !cyc_rst_q;
          sd_hi_q  <= !ior_n && !cyc_rst_q && !eight_bit;
        end
        isa_cycle_pkg::SL_PROM_WAIT: begin
          if (!private_bus_busy) begin
            sl_q    <= isa_cycle_pkg::SL_PROM_DRV;
            sd_lo_q <= 1'b1;
          end
          if (ior_n) begin
            sl_q <= isa_cycle_pkg::SL_IDLE;
          end
        end
        isa_cycle_pkg::SL_PROM_DRV: begin
          sd_q <= {8'h00, private_data_lines};
          if (ior_n) begin
            sl_q    <= isa_cycle_pkg::SL_IDLE;
            sd_lo_q <= 1'b0;
          end
        end
        isa_cycle_pkg::SL_ROM_LO: begin
          sl_cnt_q <= sl_cnt_q + 8'h01;
          if (phase_end(sl_cnt_q, `ROMCS_NCLK)) begin
            sl_cnt_q   <= 8'h00;
            sd_q[7:0]  <= private_data_lines;
            rom_addr_q <= rom_addr_q + 16'h0001;
            if (eight_bit) begin
              sl_q    <= isa_cycle_pkg::SL_DONE;
              sd_lo_q <= 1'b1;
            end else begin
              sl_q <= isa_cycle_pkg::SL_ROM_HI;
            end
          end
        end
        isa_cycle_pkg::SL_ROM_HI: begin
          sl_cnt_q <= sl_cnt_q + 8'h01;
          if (phase_end(sl_cnt_q, `ROMCS_NCLK)) begin
            sl_cnt_q   <= 8'h00;
            sd_q[15:8] <= private_data_lines;
            sl_q       <= isa_cycle_pkg::SL_DONE;
            sd_lo_q    <= 1'b1;
            sd_hi_q    <= 1'b1;
          end
        end
        isa_cycle_pkg::SL_DONE: begin
          if (ior_n && iow_n && memr_n) begin
            sl_q      <= isa_cycle_pkg::SL_IDLE;
            sd_lo_q   <= 1'b0;
            sd_hi_q   <= 1'b0;
            cyc_rst_q <= 1'b0;
          end
        end
        default: sl_q <= isa_cycle_pkg::SL_IDLE;
      endcase
    end
  end

  assign iochrdy_oe = (sl_q == isa_cycle_pkg::SL_REG) || (sl_q == isa_cycle_pkg::SL_PROM_WAIT) ||
                      (sl_q == isa_cycle_pkg::SL_ROM_LO) || (sl_q == isa_cycle_pkg::SL_ROM_HI);
  assign iocs16_oe  = ((sl_q == isa_cycle_pkg::SL_REG) || (sl_q == isa_cycle_pkg::SL_DONE && memr_n)) &&
                      opts_q[1] && !eight_bit && !cyc_rst_q;
  assign addr_prom_select_n = !(sl_q == isa_cycle_pkg::SL_PROM_DRV);
  assign boot_rom_select_n  = !((sl_q == isa_cycle_pkg::SL_ROM_LO) || (sl_q == isa_cycle_pkg::SL_ROM_HI));
  assign private_addr       = (sl_q == isa_cycle_pkg::SL_PROM_DRV) ? {12'h000, sa_in[3:0]} : rom_addr_q;

  // ----------------------------------------
  // Master memory write sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw_q     <= isa_cycle_pkg::MW_IDLE;
      mw_cnt_q <= 8'h00;
    end else if (srst_q) begin
      mw_q     <= isa_cycle_pkg::MW_IDLE;
      mw_cnt_q <= 8'h00;
    end else begin
      mw_cnt_q <= mw_cnt_q + 8'h01;
      unique case (mw_q)
        isa_cycle_pkg::MW_IDLE: begin
          mw_cnt_q <= 8'h00;
          if (mw_pend_q) begin
            mw_q <= isa_cycle_pkg::MW_REQ;
          end
        end
        isa_cycle_pkg::MW_REQ: begin
          mw_cnt_q <= 8'h00;
          if (!dack_n) begin
            mw_q <= isa_cycle_pkg::MW_ACQ;
          end
        end
        isa_cycle_pkg::MW_ACQ: begin
          if (phase_end(mw_cnt_q, `ACQ_NCLK)) begin
            mw_q     <= isa_cycle_pkg::MW_SETUP;
            mw_cnt_q <= 8'h00;
          end
        end
        isa_cycle_pkg::MW_SETUP: begin
          if (phase_end(mw_cnt_q, `SETUP_NCLK)) begin
            mw_q     <= isa_cycle_pkg::MW_ACTIVE;
            mw_cnt_q <= 8'h00;
          end
        end
        isa_cycle_pkg::MW_ACTIVE: begin
          if (phase_end(mw_cnt_q, wat_q)) begin
            mw_cnt_q <= mw_cnt_q;
            if (iochrdy_in) begin
              mw_q     <= isa_cycle_pkg::MW_HOLD;
              mw_cnt_q <= 8'h00;
            end
          end
        end
        isa_cycle_pkg::MW_HOLD: begin
          if (phase_end(mw_cnt_q, `DHOLD_NCLK)) begin
            mw_q     <= isa_cycle_pkg::MW_RECOV;
            mw_cnt_q <= 8'h00;
          end
        end
        isa_cycle_pkg::MW_RECOV: begin
          if (phase_end(mw_cnt_q, rec_nclk)) begin
            mw_q     <= isa_cycle_pkg::MW_IDLE;
            mw_cnt_q <= 8'h00;
          end
        end
        default: mw_q <= isa_cycle_pkg::MW_IDLE;
      endcase
    end
  end

  assign drq        = (mw_q != isa_cycle_pkg::MW_IDLE);
  assign master_n   = (mw_q == isa_cycle_pkg::MW_IDLE) || (mw_q == isa_cycle_pkg::MW_REQ);
  assign addr_oe    = mw_drive;
  assign cmd_oe     = mw_drive;
  assign memw_n_out = !(mw_q == isa_cycle_pkg::MW_ACTIVE);
  assign sa_out     = mw_addr_q[19:0];
  assign la_out     = mw_addr_q[23:17];
  assign sbhe_n_out = 1'b0;
  assign sd_out     = mw_drive ? mw_data_q : sd_q;
  assign sd_lo_oe   = mw_drive || sd_lo_q;
  assign sd_hi_oe   = mw_drive || sd_hi_q;

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  assign apb_wr  = psel && penable && pwrite;
  assign apb_map = (paddr == `APB_CMD) || (paddr == `APB_MW_ADDR) || (paddr == `APB_MW_DATA) ||
                   (paddr == `APB_OPTS) || (paddr == `APB_STATUS) || (paddr == `APB_CFG);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_map;
  assign prdata  = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw_addr_q <= 24'h000000;
      mw_data_q <= 16'h0000;
      opts_q    <= 2'h0;
    end else if (srst_q) begin
      mw_addr_q <= 24'h000000;
      mw_data_q <= 16'h0000;
      opts_q    <= 2'h0;
    end else if (apb_wr && mw_q == isa_cycle_pkg::MW_IDLE) begin
      if (paddr == `APB_MW_ADDR) begin
        mw_addr_q <= pwdata[23:0];
      end
      if (paddr == `APB_MW_DATA) begin
        mw_data_q <= pwdata[15:0];
      end
      if (paddr == `APB_OPTS) begin
        opts_q <= pwdata[1:0];
      end
    end
  end

  // Start request: a new start wins over the clear taken by the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw_pend_q <= 1'b0;
    end else if (srst_q) begin
      mw_pend_q <= 1'b0;
    end else if (apb_wr && paddr == `APB_CMD && pwdata[0]) begin
      mw_pend_q <= 1'b1;
    end else if (mw_q == isa_cycle_pkg::MW_IDLE) begin
      mw_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `APB_MW_ADDR: prdata_q <= {8'h00, mw_addr_q};
        `APB_MW_DATA: prdata_q <= {16'h0000, mw_data_q};
        `APB_OPTS:    prdata_q <= {30'h00000000, opts_q};
        `APB_STATUS:  prdata_q <= {22'h000000, sl_q, mw_q, eight_bit, sbhe_seen_q, mw_pend_q, drq};
        `APB_CFG:     prdata_q <= {12'h000, wat_q, cfg_q};
        default:      prdata_q <= 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: isa_bus_cycle_properties.sv
// Checker for the ISA bus cycle block, bound into its top module.
// Assumes 7 pclk per network clock and ISA inputs synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module isa_bus_cycle_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // ISA
  input wire logic        aen,
  input wire logic [19:0] sa_in,
  input wire logic        sbhe_n_in,
  input wire logic        ior_n,
  input wire logic        iow_n,
  input wire logic        iochrdy_in,
  input wire logic        memw_n_out,
  input wire logic        addr_oe,
  input wire logic        sd_hi_oe,
  input wire logic        iochrdy_oe,
  input wire logic        iocs16_oe,
  input wire logic        drq,
  input wire logic        core_reset,
  // Private bus
  input wire logic        private_bus_busy,
  input wire logic        addr_prom_select_n,
  input wire logic        boot_rom_select_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] rom_q;
  logic       wide_q;
  // Select width in pclk; too long for a repetition count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rom_q <= 8'h00;
    else rom_q <= boot_rom_select_n ? 8'h00 : rom_q + 8'h01;
  // A soft reset forgets a 16-bit host just as a hard one does
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wide_q <= 1'b0;
    else wide_q <= !core_reset && (wide_q || !sbhe_n_in);
  sequence reg_cmd;
    !aen && sa_in[9:3] == 7'h62 && sa_in[2:1] != 2'h2 && ($fell(ior_n) || $fell(iow_n));
  endsequence
  sequence ready_pulse;
    ##1 iochrdy_oe ##1 !iochrdy_oe;
  endsequence
  a_reg_ready: assert property (reg_cmd |-> ready_pulse)
    else $error("register cycle ready pulse wrong");
  a_prom_wait: assert property (!aen && sa_in[9:4] == 6'h30 && $fell(ior_n) && private_bus_busy
    ##1 private_bus_busy |=> iochrdy_oe && addr_prom_select_n)
    else $error("address PROM did not wait for private bus");
  a_prom_lanes: assert property (!addr_prom_select_n |-> !iochrdy_oe && !sd_hi_oe && !iocs16_oe)
    else $error("address PROM cycle drives wrong lines");
  a_setup_clock: assert property ($fell(memw_n_out) |-> $past(addr_oe, 7) && !$past(addr_oe, 8))
    else $error("address setup before write strobe not one clock");
  a_data_hold: assert property ($rose(memw_n_out) |-> addr_oe [*7] ##1 !addr_oe)
    else $error("write data hold not one clock");
  a_wait_ready: assert property (!memw_n_out && !iochrdy_in |=> !memw_n_out)
    else $error("write strobe ended while not ready");
  a_rom_width: assert property ($rose(boot_rom_select_n) |-> rom_q == 8'h15 || rom_q == 8'h2A)
    else $error("boot ROM select width wrong");
  a_narrow_bus: assert property (!wide_q && !addr_oe |-> !sd_hi_oe && !iocs16_oe)
    else $error("high lane used by a narrow host");
  a_recovery_end: assert property ($rose(memw_n_out) |-> drq ##20 drq ##[1:16] !drq)
    else $error("command recovery length wrong");
  a_reset_read: assert property (!aen && sa_in[9:0] == 10'h314 && $fell(ior_n)
    |=> ##[0:1] core_reset && !iocs16_oe ##1 !core_reset) else $error("reset read misbehaved");
endmodule
bind isa_bus_cycle isa_bus_cycle_properties isa_bus_cycle_properties_inst (.pclk, .presetn, .aen, .sa_in,
  .sbhe_n_in, .ior_n, .iow_n, .iochrdy_in, .memw_n_out, .addr_oe, .sd_hi_oe, .iochrdy_oe, .iocs16_oe, .drq,
  .core_reset, .private_bus_busy, .addr_prom_select_n, .boot_rom_select_n);
`default_nettype wire

// file: isa_host.sv
// Host chipset model: the permanent ISA master with its DMA grant.
// Assumes cycle is called just after a rising pclk edge; the bench resolves shared wires.
`timescale 1ns/1ps
`default_nettype none
module isa_host (
  // Device lines seen by the host
  input  wire logic        pclk,
  input  wire logic        drq,
  input  wire logic        memw_n_out,
  input  wire logic        iochrdy_oe,
  input  wire logic [15:0] sd_in,
  // Lines the host drives
  output logic             aen,
  output logic      [19:0] sa_in,
  output logic             sbhe_n_in,
  output logic             ior_n,
  output logic             iow_n,
  output logic             memr_n,
  output logic             dack_n,
  output logic             boot_rom_match,
  output logic      [15:0] host_sd,
  output logic             pull
);
  int stall = 0;
  int held = 0;
  initial begin
    {aen, sbhe_n_in, ior_n, iow_n, memr_n} = 5'h1F;
    {sa_in, host_sd, boot_rom_match} = 37'h0;
  end
  always @(posedge pclk) dack_n <= !drq;
  // Slow memory: ready held low for the first stall clocks of a write
  always @(posedge pclk) begin
    held <= memw_n_out ? 0 : held + 1;
    pull <= !memw_n_out && held < stall;
  end
  // Kind 0 reads I/O, 1 writes I/O, 2 reads memory
  task automatic cycle(input logic [1:0] kind, input logic [19:0] a, input logic [15:0] d, input logic wide,
                       output logic [15:0] q);
    aen <= kind[1];
    boot_rom_match <= kind[1];
    sa_in <= a;
    host_sd <= d;
    sbhe_n_in <= !wide;
    ior_n <= kind != 2'h0;
    iow_n <= kind != 2'h1;
    memr_n <= kind != 2'h2;
    repeat (3) @(posedge pclk);
    while (iochrdy_oe) @(posedge pclk);
    @(posedge pclk);
    q = sd_in;
    {aen, sbhe_n_in, ior_n, iow_n, memr_n, boot_rom_match} <= 6'h3E;
    sa_in <= ~a;
    host_sd <= ~d;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the ISA bus cycle block with a host model.
// Assumes the private PROM bus answers at once; inputs change just after rising edges.
`include "isa_cycle_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        private_bus_busy = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, aen, sbhe_n_in, ior_n, iow_n, memr_n, iochrdy_in, dack_n, boot_rom_match, pull;
  logic        memw_n_out, sd_lo_oe, sd_hi_oe, iochrdy_oe, drq, addr_prom_select_n, boot_rom_select_n;
  logic        sbhe_n_out, master_n, cmd_oe;
  logic [19:0] sa_in, sa_out;
  logic [15:0] sd_in, sd_out, host_sd, private_addr, h;
  logic [7:0]  private_data_lines, rom_byte;
  logic [6:0]  la_out;
  int          failures = 0, num_checks = 0, cyc = 0, lo, tail, fast;
  logic [12:0] wr8 [12] = '{13'h1201, 13'h1300, 13'h105A, 13'h11A5, 13'h1202, 13'h1300, 13'h1600, 13'h1700,
                            13'h1201, 13'h1300, 13'h1603, 13'h1700};
  always #4 pclk = ~pclk;
  assign iochrdy_in = !(iochrdy_oe || pull);
  assign sd_in = {sd_hi_oe ? sd_out[15:8] : host_sd[15:8], sd_lo_oe ? sd_out[7:0] : host_sd[7:0]};
  // PROM image: a byte is a hash of its address, inverted while deselected
  assign rom_byte = private_addr[15:8] ^ private_addr[7:0];
  assign private_data_lines = (addr_prom_select_n && boot_rom_select_n) ? ~rom_byte : rom_byte;
  isa_bus_cycle isa_bus_cycle_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .aen, .sa_in, .sbhe_n_in, .ior_n, .iow_n, .memr_n, .iochrdy_in, .dack_n, .boot_rom_match, .sd_in,
    .sa_out, .la_out, .sbhe_n_out, .addr_oe(), .memw_n_out, .cmd_oe, .sd_out, .sd_lo_oe, .sd_hi_oe,
    .iochrdy_oe, .iocs16_oe(), .drq, .master_n, .private_bus_busy, .private_data_lines, .private_addr,
    .addr_prom_select_n, .boot_rom_select_n, .core_reset());
  isa_host isa_host_inst (.pclk, .drq, .memw_n_out, .iochrdy_oe, .sd_in, .aen, .sa_in, .sbhe_n_in, .ior_n,
    .iow_n, .memr_n, .dack_n, .boot_rom_match, .host_sd, .pull);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Starts a master write and times strobe width and the tail to the end of request
  task automatic mwrite();
    apb(1'b1, `APB_CMD, 32'h1, q);
    lo = 0;
    tail = 0;
    while (memw_n_out) @(posedge pclk);
    chk({la_out, sa_out, sd_out, sbhe_n_out, master_n, cmd_oe}, {7'h55, 20'hBCDE4, 16'h5AA5, 3'b001});
    while (!memw_n_out) begin
      lo++;
      @(posedge pclk);
    end
    while (drq) begin
      tail++;
      @(posedge pclk);
    end
  endtask
  task automatic results();
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end
  // ---
  // Scenarios
  // ---
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `APB_CFG, 32'h0, q);
    chk(q, {12'h000, `WAT_RESET, `CFG_RESET});
    apb(1'b0, 12'h020, 32'h0, q);
    chk({err, q}, {1'b1, 32'h0});
    apb(1'b1, `APB_MW_ADDR, 32'h00ABCDE4, q);
    apb(1'b1, `APB_MW_DATA, 32'h00005AA5, q);
    mwrite();
    chk(lo, 7 * `WAT_RESET);
    fast = tail;
    isa_host_inst.stall = 60;
    mwrite();
    chk(lo >= 60, 1);
    isa_host_inst.stall = 0;
    foreach (wr8[i]) isa_host_inst.cycle(2'h1, {15'h0018, wr8[i][12:8]}, {8'h00, wr8[i][7:0]}, 1'b0, h);
    isa_host_inst.cycle(2'h0, 20'h00311, 16'hFFFF, 1'b0, h);
    chk(h[7:0], 8'hA5);
    apb(1'b0, `APB_CFG, 32'h0, q);
    chk(q, 32'h00030000);
    mwrite();
    chk(lo, 21);
    chk(tail - fast, 14);
    isa_host_inst.cycle(2'h0, 20'h00314, 16'hFFFF, 1'b0, h);
    isa_host_inst.cycle(2'h1, 20'h00314, 16'h0000, 1'b0, h);
    apb(1'b0, `APB_CFG, 32'h0, q);
    chk(q, {12'h000, `WAT_RESET, `CFG_RESET});
    fork
      isa_host_inst.cycle(2'h0, 20'h00303, 16'hFFFF, 1'b0, h);
      begin
        repeat (10) @(posedge pclk);
        private_bus_busy <= 1'b0;
      end
    join
    chk(h[7:0], 8'h03);
    isa_host_inst.cycle(2'h2, 20'h1A011, 16'hFFFF, 1'b0, h);
    chk(h, 16'hFFB1);
    isa_host_inst.cycle(2'h0, 20'h00310, 16'hFFFF, 1'b1, h);
    chk(h, 16'h0000);
    isa_host_inst.cycle(2'h2, 20'h1A010, 16'hFFFF, 1'b1, h);
    chk(h, 16'hB1B0);
    apb(1'b1, `APB_OPTS, 32'h00000003, q);
    isa_host_inst.cycle(2'h0, 20'h00313, 16'hFFFF, 1'b1, h);
    chk(h, 16'hFF00);
    results();
  end
endmodule
`default_nettype wire
